// >>> rtl/serial_link_dev.sv
// Purpose: Device end: buffer access, descriptor table, channel poller, frame lock
// Assumes: Link pins are asynchronous to clk; channel status inputs are on clk
// Notes: Overview of operation and tags follow
// Overview of operation
// [R1] Host writes address, write flag, buffer flag
// [R2] Completion flag set after buffer write
// [R3] Host writes address, read flag, buffer flag
// [R4] Completion flag; read byte in data bits 7:0
// [R5] Poll channel descriptors in turn, low priority
// [R6] Async channels: packet ready or space free
// [R7] Isochronous: valid or empty count above block
// [R8] Ping-pong pair per channel, 128-bit descriptor
// [R9] Sixty-four descriptors, one per channel
// [R10] Descriptor at fixed address in table
// [R11] Channel enable bit, software and hardware update
// [R12] Errored async packet skipped or resent
// [R13] Lock status bit 7 reads one when synced
// [R14] Lock after three aligned sync patterns
// [R15] Unlock after two missing sync patterns
// [R16] Locked: misplaced sync patterns ignored
// [R17] Speed field selects clock ratio, pin mode zero
// [R18] Software writes zero to bit 5
// [R19] Enable bit connects the bus lines
// [R20] Reset: unlocked, completion flag clear
`timescale 1ns/100ps
`default_nettype none
`include "serial_link_cfg.svh"
module serial_link_dev
  import serial_link_pkg::*;
#(
  parameter int NCH = 64,
  parameter int CW = 12,
  parameter int FRAME_BITS = 256,
  parameter logic [7:0] FSYNC_PAT = 8'hA5
)(
  input wire logic clk,
  input wire logic rst_b,
  reg_port_if.dev bus,
  input wire logic bus_clock_line,
  input wire logic bus_signal_line,
  input wire logic bus_data_line_i,
  output logic bus_data_line_o,
  output logic bus_data_line_oe_b,
  input wire logic tx_bit,
  input wire logic tx_en,
  output logic rx_bit,
  output logic rx_bit_valid,
  input wire logic [NCH-1:0] ch_iso,
  input wire logic [NCH-1:0] ch_pkt_avail,
  input wire logic [NCH-1:0] ch_space_ok,
  input wire logic [NCH-1:0][CW-1:0] ch_valid_bytes,
  input wire logic [NCH-1:0][CW-1:0] ch_empty_bytes,
  input wire logic [CW-1:0] block_size,
  input wire logic hw_ce_clr,
  input wire logic [$clog2(NCH)-1:0] hw_ce_chan,
  input wire logic rx_err,
  output logic alert,
  output logic [$clog2(NCH)-1:0] alert_chan,
  output logic retx_req,
  output logic skip_req,
  output logic [12:0] clk_ratio,
  output logic lock_status
);
  localparam int CH_W = $clog2(NCH);
  localparam int DI_W = CH_W + 2;
  localparam int FW = $clog2(FRAME_BITS);
  localparam int DBR_DEPTH = 1 << (`MADR_ADDR_MSB + 1);
  localparam logic [FW-1:0] POS_LAST = FW'(FRAME_BITS - 1);

  if (NCH < 2 || NCH > 64) $error("NCH must lie between 2 and 64");
  if (FRAME_BITS < 16) $error("FRAME_BITS too small for a sync pattern");

  // Ratio decode of the three-bit speed field; code 7 selects nothing
  function automatic logic [12:0] ratio_of(input logic [2:0] code);
    case (code)
      3'h0: ratio_of = 13'h0100;
      3'h1: ratio_of = 13'h0200;
      3'h2: ratio_of = 13'h0400;
      3'h3: ratio_of = 13'h0800;
      3'h4: ratio_of = 13'h0C00;
      3'h5: ratio_of = 13'h1000;
      3'h6: ratio_of = 13'h1800;
      default: ratio_of = 13'h0000;
    endcase
  endfunction

  logic [7:0] dbr_mem [0:DBR_DEPTH-1];
  logic [31:0] desc_mem [0:NCH*4-1];
  logic [31:0] madr_q, data_q, rdata_q;
  logic pend_q, transfer_complete_flag_q;
  logic en_q, retx_q, pinmode_q, lock_q;
  logic [2:0] speed_q;
  logic [CH_W-1:0] poll_q, alert_chan_q;
  logic [NCH-1:0] prev_q;
  logic alert_q, retx_req_q, skip_req_q;
  logic [12:0] ratio_q;
  logic clk_s1_q, clk_s2_q, clk_s3_q, sig_s1_q, sig_s2_q, dat_s1_q, dat_s2_q;
  logic [6:0] shift_q;
  logic [FW-1:0] pos_q;
  logic [1:0] good_q, miss_q;
  logic dout_q, doe_b_q, rx_bit_q, rx_valid_q;

  // Register port decode
  wire wr_madr = bus.wr && (bus.addr == `OFS_MEM_ADDR);
  wire wr_mctl = bus.wr && (bus.addr == `OFS_MEM_CTRL);
  wire wr_data = bus.wr && (bus.addr == `OFS_MEM_DATA0);
  wire wr_link = bus.wr && (bus.addr == `OFS_LINK_CTRL);
  wire acc_wnr = madr_q[`MADR_WNR_BIT];
  wire acc_tb = madr_q[`MADR_TB_BIT];
  wire [`MADR_ADDR_MSB:0] acc_addr = madr_q[`MADR_ADDR_MSB:0];
  wire [DI_W-1:0] acc_didx = acc_addr[DI_W-1:0];
  wire [31:0] link_word = {24'h00_0000, lock_q, pinmode_q, 1'b0, speed_q, retx_q, en_q};
  wire [31:0] read_mux = (bus.addr == `OFS_MEM_ADDR) ? madr_q :
                         (bus.addr == `OFS_MEM_CTRL) ? {31'h0000_0000, transfer_complete_flag_q} :
                         (bus.addr == `OFS_MEM_DATA0) ? data_q :
                         (bus.addr == `OFS_LINK_CTRL) ? link_word : `RST_WORD;

  // Address register and pending flag; an access runs one cycle after the write
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      madr_q <= `RST_WORD;
      pend_q <= 1'b0;
    end
    else
    begin
      if (wr_madr)
        madr_q <= bus.wdata; // R1 R3
      pend_q <= wr_madr;
    end
  end

  // Completion flag: completion wins over a software clear
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      transfer_complete_flag_q <= 1'b0; // R20
    else if (pend_q)
      transfer_complete_flag_q <= 1'b1; // R2 R4
    else if (wr_madr || (wr_mctl && !bus.wdata[`MCTL_TRANSFER_COMPLETE_FLAG_BIT]))
      transfer_complete_flag_q <= 1'b0;
  end

  // Buffer memory: byte write on a direct write access
  always_ff @(posedge clk)
  begin
    if (pend_q && acc_tb && acc_wnr)
      dbr_mem[acc_addr] <= data_q[7:0]; // R2
  end

  // Descriptor table: software word access, hardware may clear a channel enable
  always_ff @(posedge clk)
  begin
    if (pend_q && !acc_tb && acc_wnr)
      desc_mem[acc_didx] <= data_q; // R8 R10 R11
    else if (hw_ce_clr)
      desc_mem[{hw_ce_chan, `DESC_CE_WORD}][`DESC_CE_BIT] <= 1'b0; // R11
  end

  // Data register: software write, or result of a read access
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      data_q <= `RST_WORD;
    else if (pend_q && !acc_wnr)
      data_q <= acc_tb ? {24'h00_0000, dbr_mem[acc_addr]} : desc_mem[acc_didx]; // R4
    else if (wr_data)
      data_q <= bus.wdata;
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata_q <= `RST_WORD;
    else
      rdata_q <= bus.rd ? read_mux : `RST_WORD;
  end
  assign bus.rdata = rdata_q;

  // Link control; the zero bit is never stored
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      en_q <= 1'b0;
      retx_q <= 1'b0;
      pinmode_q <= 1'b0;
      speed_q <= 3'h0;
    end
    else if (wr_link)
    begin
      en_q <= bus.wdata[`LINK_EN_BIT];
      retx_q <= bus.wdata[`LINK_RETX_BIT];
      pinmode_q <= bus.wdata[`LINK_PINMODE_BIT];
      speed_q <= bus.wdata[`LINK_SPEED_MSB:`LINK_SPEED_LSB]; // R18
    end
  end

  // Poller condition for the channel under inspection
  wire poll_ce = desc_mem[{poll_q, `DESC_CE_WORD}][`DESC_CE_BIT]; // R9 R11
  wire iso_hit = (ch_valid_bytes[poll_q] > block_size) ||
                 (ch_empty_bytes[poll_q] > block_size); // R7
  wire async_hit = ch_pkt_avail[poll_q] || ch_space_ok[poll_q]; // R6
  wire poll_cond = poll_ce && (ch_iso[poll_q] ? iso_hit : async_hit);
  wire [CH_W-1:0] poll_next = (poll_q == CH_W'(NCH - 1)) ? '0 : poll_q + 1'b1;

  // Low priority walk: stalls only in the cycle in which a pending host access runs
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      poll_q <= '0;
      prev_q <= '0;
      alert_q <= 1'b0;
      alert_chan_q <= '0;
    end
    else
    begin
      alert_q <= 1'b0;
      if (!pend_q)
      begin
        poll_q <= poll_next; // R5
        prev_q[poll_q] <= poll_cond;
        alert_q <= poll_cond && !prev_q[poll_q]; // R5
        alert_chan_q <= poll_q;
      end
    end
  end

  // Errored async packet: resend or skip as the option says
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      retx_req_q <= 1'b0;
      skip_req_q <= 1'b0;
      ratio_q <= 13'h0000;
    end
    else
    begin
      retx_req_q <= rx_err && retx_q; // R12
      skip_req_q <= rx_err && !retx_q; // R12
      ratio_q <= pinmode_q ? 13'h0000 : ratio_of(speed_q); // R17
    end
  end

  // Pin synchronisers; first stages feed only the second
  always_ff @(posedge clk)
  begin
    clk_s1_q <= bus_clock_line;
    clk_s2_q <= clk_s1_q;
    clk_s3_q <= clk_s2_q;
    sig_s1_q <= bus_signal_line;
    sig_s2_q <= sig_s1_q;
    dat_s1_q <= bus_data_line_i;
    dat_s2_q <= dat_s1_q;
  end

  wire clk_rise = clk_s2_q && !clk_s3_q;
  wire sync_hit = ({shift_q, sig_s2_q} == FSYNC_PAT);
  wire at_last = (pos_q == POS_LAST);

  // Frame lock tracker, held clear while the interface is off
  always_ff @(posedge clk)
  begin
    if (!rst_b || !en_q)
    begin
      shift_q <= 7'h00;
      pos_q <= '0;
      good_q <= 2'h0;
      miss_q <= 2'h0;
      lock_q <= 1'b0; // R20 R19
    end
    else if (clk_rise)
    begin
      shift_q <= {shift_q[5:0], sig_s2_q};
      pos_q <= at_last ? '0 : pos_q + 1'b1;
      if (lock_q)
      begin
        if (at_last) // R16
        begin
          miss_q <= sync_hit ? 2'h0 : miss_q + 1'b1;
          if (!sync_hit && (miss_q + 1'b1 == `LOCK_MISS_FRAMES))
          begin
            lock_q <= 1'b0; // R15
            good_q <= 2'h0;
          end
        end
      end
      else if (sync_hit)
      begin
        pos_q <= '0;
        good_q <= (at_last && good_q != 2'h0) ? good_q + 1'b1 : 2'h1;
        if (at_last && (good_q + 1'b1 == `LOCK_GOOD_FRAMES))
        begin
          lock_q <= 1'b1; // R14
          miss_q <= 2'h0;
        end
      end
      else if (at_last)
        good_q <= 2'h0;
    end
  end

  // Bus data line: driven only while enabled; rx_bit always follows it, rx_bit_valid pulses only while enabled
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dout_q <= 1'b0;
      doe_b_q <= 1'b1;
      rx_bit_q <= 1'b0;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      dout_q <= tx_bit;
      doe_b_q <= !(en_q && tx_en); // R19
      rx_bit_q <= dat_s2_q;
      rx_valid_q <= en_q && clk_rise; // R19
    end
  end

  assign bus_data_line_o = dout_q;
  assign bus_data_line_oe_b = doe_b_q;
  assign rx_bit = rx_bit_q;
  assign rx_bit_valid = rx_valid_q;
  assign alert = alert_q;
  assign alert_chan = alert_chan_q;
  assign retx_req = retx_req_q;
  assign skip_req = skip_req_q;
  assign clk_ratio = ratio_q;
  assign lock_status = lock_q; // R13
endmodule
`default_nettype wire

// >>> shared/serial_link_cfg.svh
// Purpose: Register map, field positions and fixed counts of the serial bus interface
// Assumes: Included by bare name by the package, both ends and the bench
// Notes: Definitions only
`ifndef SERIAL_LINK_CFG_SVH
`define SERIAL_LINK_CFG_SVH
// Register offsets on the host port
`define OFS_MEM_ADDR 4'h0
`define OFS_MEM_CTRL 4'h4
`define OFS_MEM_DATA0 4'h8
`define OFS_LINK_CTRL 4'hC
// Memory address register fields
`define MADR_WNR_BIT 31
`define MADR_TB_BIT 30
`define MADR_ADDR_MSB 13
// Memory control register fields
`define MCTL_TRANSFER_COMPLETE_FLAG_BIT 0
// Link control and status fields
`define LINK_EN_BIT 0
`define LINK_RETX_BIT 1
`define LINK_SPEED_LSB 2
`define LINK_SPEED_MSB 4
`define LINK_ZERO_BIT 5
`define LINK_PINMODE_BIT 6
`define LINK_LOCK_BIT 7
// Descriptor layout: channel enable sits in word 3
`define DESC_CE_WORD 2'h3
`define DESC_CE_BIT 31
// Frame lock counts
`define LOCK_GOOD_FRAMES 2'h3
`define LOCK_MISS_FRAMES 2'h2
// Reset values
`define RST_WORD 32'h0000_0000
`define RST_BYTE 8'h00
`endif

// >>> shared/serial_link_pkg.sv
// Purpose: Shared types of the serial bus interface
// Assumes: Header serial_link_cfg.svh holds the field numbers; state codes are set here
// Notes: Types only
`default_nettype none
`include "serial_link_cfg.svh"
package serial_link_pkg;
  typedef logic [`MADR_ADDR_MSB:0] mem_addr_t;
  typedef logic [3:0] reg_addr_t;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_POLL = 7'h04,
    ST_WAIT = 7'h08,
    ST_CHECK = 7'h10,
    ST_FWAIT = 7'h20,
    ST_FCHK = 7'h40
  } host_state_t;
endpackage
`default_nettype wire

// >>> shared/reg_port_if.sv
// Purpose: Register port joining the host controller end and the device end
// Assumes: Both ends share clk
// Notes: Read data stand in the cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
interface reg_port_if;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  modport host (output addr, output wdata, output wr, output rd, input rdata);
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
endinterface
`default_nettype wire

// >>> rtl/serial_link_host.sv
// Purpose: Host controller end: runs buffer and descriptor accesses, writes link setup
// Assumes: Device answers reads one cycle after the strobe
// Notes: One access at a time; commands while busy are ignored
`timescale 1ns/100ps
`default_nettype none
`include "serial_link_cfg.svh"
module serial_link_host
  import serial_link_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  reg_port_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_buffer,
  input wire logic [`MADR_ADDR_MSB:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  input wire logic cfg_valid,
  input wire logic cfg_enable,
  input wire logic cfg_retx,
  input wire logic cfg_pinmode,
  input wire logic [2:0] cfg_speed,
  output logic busy,
  output logic done,
  output logic [31:0] rdata
);
  host_state_t state_q;
  logic [3:0] addr_q;
  logic [31:0] wdata_q, rdata_q, madr_word_q;
  logic wr_q, rd_q, busy_q, done_q, write_q;

  // Address word and link word as the device expects them
  wire [31:0] madr_word = {cmd_write, cmd_buffer, 16'h0000, cmd_addr}; // R1 R3
  wire [31:0] link_word = {24'h00_0000, 1'b0, cfg_pinmode, 1'b0, cfg_speed, cfg_retx, cfg_enable};
  wire transfer_complete_flag_seen = bus.rdata[`MCTL_TRANSFER_COMPLETE_FLAG_BIT];

  // Access sequencer; bus strobes last one cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      addr_q <= 4'h0;
      wdata_q <= `RST_WORD;
      madr_word_q <= `RST_WORD;
      rdata_q <= `RST_WORD;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      write_q <= 1'b0;
    end
    else
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      done_q <= 1'b0;
      unique case (state_q)
        ST_IDLE:
        begin
          if (cmd_valid)
          begin
            busy_q <= 1'b1;
            write_q <= cmd_write;
            madr_word_q <= madr_word;
            wr_q <= cmd_write; // Data word goes first on a write
            addr_q <= `OFS_MEM_DATA0;
            wdata_q <= cmd_wdata;
            state_q <= ST_ADDR;
          end
          else if (cfg_valid)
          begin
            wr_q <= 1'b1;
            addr_q <= `OFS_LINK_CTRL;
            wdata_q <= link_word; // R18
          end
        end
        ST_ADDR:
        begin
          wr_q <= 1'b1;
          addr_q <= `OFS_MEM_ADDR;
          wdata_q <= madr_word_q; // R1 R3
          state_q <= ST_POLL;
        end
        ST_POLL:
        begin
          rd_q <= 1'b1;
          addr_q <= `OFS_MEM_CTRL;
          state_q <= ST_WAIT;
        end
        ST_WAIT:
          state_q <= ST_CHECK;
        ST_CHECK:
        begin
          if (!transfer_complete_flag_seen)
            state_q <= ST_POLL;
          else if (write_q)
          begin
            done_q <= 1'b1; // R2
            busy_q <= 1'b0;
            state_q <= ST_IDLE;
          end
          else
          begin
            rd_q <= 1'b1;
            addr_q <= `OFS_MEM_DATA0;
            state_q <= ST_FWAIT;
          end
        end
        ST_FWAIT:
          state_q <= ST_FCHK;
        ST_FCHK:
        begin
          rdata_q <= bus.rdata; // R4
          done_q <= 1'b1;
          busy_q <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
  assign busy = busy_q;
  assign done = done_q;
  assign rdata = rdata_q;
endmodule
`default_nettype wire

// >>> sim/serial_link_asserts.sv
// Purpose: Protocol checks on the register port between host end and device end
// Assumes: Sees the port signals with clk and rst_b only
// Notes: Offsets and bit positions come from the shared header
`timescale 1ns/100ps
`default_nettype none
`include "serial_link_cfg.svh"
module serial_link_asserts
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata
);
  // One domain, so clocking and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Named decodes keep the properties short
  wire logic wr_madr = wr && (addr == `OFS_MEM_ADDR);
  wire logic rd_mctl = rd && (addr == `OFS_MEM_CTRL);
  wire logic rd_data = rd && (addr == `OFS_MEM_DATA0);
  logic buf_rd_q;
  // Remember whether the last address write started a buffer read
  always_ff @(posedge clk)
    if (!rst_b)
      buf_rd_q <= 1'b0;
    else if (wr_madr)
      buf_rd_q <= wdata[`MADR_TB_BIT] && !wdata[`MADR_WNR_BIT];
  a_strobes_exclusive: assert property (!(wr && rd))
    else $error("write and read strobes high together");
  a_rdata_after_read: assert property (rdata != 32'h0000_0000 |-> $past(rd))
    else $error("read data seen without a read one cycle before");
  a_addr_pad_zero: assert property (wr_madr |-> wdata[29:14] == 16'h0000)
    else $error("address register write carries stray bits");
  a_zero_bit_written: assert property (wr && addr == `OFS_LINK_CTRL |->
    !wdata[`LINK_ZERO_BIT])
    else $error("link control written with bit 5 set");
  a_poll_after_addr: assert property (wr_madr |=> rd_mctl)
    else $error("control register not polled after address write");
  // The first poll meets the edge that sets the flag, so the second poll must see it
  a_flag_after_buffer: assert property ((wr_madr && wdata[`MADR_TB_BIT]) ##1 rd_mctl
    ##3 rd_mctl |=> rdata[`MCTL_TRANSFER_COMPLETE_FLAG_BIT])
    else $error("completion flag not set by the second poll after a buffer access");
  a_byte_zero_ext: assert property (rd_data && buf_rd_q |=> rdata[31:8] == 24'h00_0000)
    else $error("buffer read byte not zero extended");
  a_read_spacing: assert property (rd |=> !rd)
    else $error("host reads on two cycles in a row");
  // Main traffic kinds on the port
  c_buf_write: cover property (wr_madr && wdata[31] && wdata[30]);
  c_buf_read: cover property (wr_madr && !wdata[31] && wdata[30]);
  c_link_write: cover property (wr && addr == `OFS_LINK_CTRL);
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: Self-checking bench joining the host end and the device end
// Assumes: Short frames of 16 bit periods keep the lock tests brief
// Notes: Ordinary accesses run from a row table; link, poller and lock cases follow
`timescale 1ns/100ps
`default_nettype none
`include "serial_link_cfg.svh"
module tb_top
  import serial_link_pkg::*;
;
  localparam int FB = 16;
  typedef struct packed {logic w; logic b; mem_addr_t a; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_buffer = 1'b0, cfg_valid = 1'b0;
  logic cfg_enable = 1'b0, cfg_retx = 1'b0, cfg_pinmode = 1'b0;
  logic [2:0] cfg_speed = 3'h0;
  mem_addr_t cmd_addr = 14'h0000;
  logic [31:0] cmd_wdata = 32'h0, hrdata;
  logic lclk = 1'b0, lsig = 1'b0, ldat = 1'b1, tx_bit = 1'b0, tx_en = 1'b0;
  logic [63:0] ch_iso = '0, ch_pkt = '0, ch_space = '0;
  logic [63:0][11:0] ch_valid = '0, ch_empty = '0;
  logic [11:0] blk = 12'h040;
  logic ce_clr = 1'b0, rx_err = 1'b0;
  logic [5:0] ce_chan = 6'h00, alert_chan, alert_last;
  logic busy, done, data_o, oe_b, rx_bit, rx_valid, alert, retx_req, skip_req, lock;
  logic [12:0] clk_ratio;
  int miscompares = 0, comparisons = 0, alert_hits = 0, edge_cnt = 0;
  logic [12:0] ratio [8] = '{13'h0100, 13'h0200, 13'h0400, 13'h0800,
                             13'h0C00, 13'h1000, 13'h1800, 13'h0000};
  // Buffer rows pair with their read-back, and the high data bits must not survive
  row_t rows [8] = '{
    '{1'b1, 1'b1, 14'h0000, 32'h1234_565A, 32'h0},
    '{1'b1, 1'b1, 14'h3FFF, 32'hFFFF_FFC3, 32'h0},
    '{1'b0, 1'b1, 14'h0000, 32'h0, 32'h0000_005A},
    '{1'b0, 1'b1, 14'h3FFF, 32'h0, 32'h0000_00C3},
    '{1'b1, 1'b0, 14'h0017, 32'h8000_1234, 32'h0},
    '{1'b0, 1'b0, 14'h0017, 32'h0, 32'h8000_1234},
    '{1'b1, 1'b0, 14'h00FC, 32'hDEAD_BEEF, 32'h0},
    '{1'b0, 1'b0, 14'h00FC, 32'h0, 32'hDEAD_BEEF}};
  reg_port_if port ();
  serial_link_host u_serial_link_host (.clk(clk), .rst_b(rst_b), .bus(port),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_buffer(cmd_buffer),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cfg_valid(cfg_valid),
    .cfg_enable(cfg_enable), .cfg_retx(cfg_retx), .cfg_pinmode(cfg_pinmode),
    .cfg_speed(cfg_speed), .busy(busy), .done(done), .rdata(hrdata));
  serial_link_dev #(.FRAME_BITS(FB)) u_serial_link_dev (.clk(clk), .rst_b(rst_b), .bus(port),
    .bus_clock_line(lclk), .bus_signal_line(lsig), .bus_data_line_i(ldat),
    .bus_data_line_o(data_o), .bus_data_line_oe_b(oe_b), .tx_bit(tx_bit), .tx_en(tx_en),
    .rx_bit(rx_bit), .rx_bit_valid(rx_valid), .ch_iso(ch_iso), .ch_pkt_avail(ch_pkt),
    .ch_space_ok(ch_space), .ch_valid_bytes(ch_valid), .ch_empty_bytes(ch_empty),
    .block_size(blk), .hw_ce_clr(ce_clr), .hw_ce_chan(ce_chan), .rx_err(rx_err),
    .alert(alert), .alert_chan(alert_chan), .retx_req(retx_req), .skip_req(skip_req),
    .clk_ratio(clk_ratio), .lock_status(lock));
  serial_link_asserts u_serial_link_asserts (.clk(clk), .rst_b(rst_b), .addr(port.addr),
    .wdata(port.wdata), .wr(port.wr), .rd(port.rd), .rdata(port.rdata));
  // 200 MHz system clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // Logs of alert pulses and link edges seen by the device
  always @(posedge clk)
  begin
    if (alert === 1'b1)
    begin
      alert_hits <= alert_hits + 1;
      alert_last <= alert_chan;
    end
    if (rx_valid === 1'b1)
      edge_cnt <= edge_cnt + 1;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One host command; waits on done with a bound so a stuck access cannot hang
  task automatic run_cmd(input logic w, input logic b, input mem_addr_t a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_buffer <= b;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    check("busy", 32'h1, {31'h0, busy});
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (done !== 1'b1 && n < 60);
    check("done", 32'h1, {31'h0, done});
    check("busy after done", 32'h0, {31'h0, busy});
  endtask
  task automatic set_link(input logic en, input logic rt, input logic pm, input logic [2:0] sp);
    @(posedge clk);
    cfg_valid <= 1'b1;
    cfg_enable <= en;
    cfg_retx <= rt;
    cfg_pinmode <= pm;
    cfg_speed <= sp;
    @(posedge clk);
    cfg_valid <= 1'b0;
    repeat (5) @(negedge clk);
  endtask
  // Alerts are counted over a full poll sweep, not waited on blindly
  task automatic expect_alert(input int hits, input logic [5:0] ch);
    int base;
    base = alert_hits;
    repeat (400) @(negedge clk);
    check("alert count", hits, alert_hits - base);
    check("alert channel", ch, alert_last);
  endtask
  // Link clock runs only inside frames; the signal line flips once released
  // The data line follows the signal bits so the received bit is seen to move
  task automatic send_frame(input logic [FB-1:0] bits);
    for (int i = FB - 1; i >= 0; i--)
    begin
      lsig <= bits[i];
      ldat <= bits[i];
      #32 lclk <= 1'b1;
      #32 lclk <= 1'b0;
    end
    lsig <= ~lsig;
    repeat (6) @(negedge clk);
  endtask
  initial
  begin
    #200000;
    miscompares++;
    print_verdict();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check("lock", 32'h0, {31'h0, lock});
    check("oe_b", 32'h1, {31'h0, oe_b});
    foreach (rows[i])
    begin
      run_cmd(rows[i].w, rows[i].b, rows[i].a, rows[i].d);
      if (!rows[i].w) check("read data", rows[i].e, hrdata);
    end
    for (int c = 0; c < 64; c++)
      run_cmd(1'b1, 1'b0, {6'h00, c[5:0], 2'h3}, 32'h8000_0000);
    @(posedge clk);
    ch_pkt[7] <= 1'b1;
    expect_alert(1, 6'd7);
    @(posedge clk);
    ch_space[11] <= 1'b1;
    expect_alert(1, 6'd11);
    @(posedge clk);
    ch_iso[9] <= 1'b1;
    ch_valid[9] <= 12'h040;
    expect_alert(0, 6'd11);
    @(posedge clk);
    ch_valid[9] <= 12'h041;
    expect_alert(1, 6'd9);
    @(posedge clk);
    ch_iso[10] <= 1'b1;
    ch_empty[10] <= 12'h041;
    expect_alert(1, 6'd10);
    @(posedge clk);
    ce_clr <= 1'b1;
    ce_chan <= 6'd12;
    @(posedge clk);
    ce_clr <= 1'b0;
    ch_pkt[12] <= 1'b1;
    expect_alert(0, 6'd10);
    run_cmd(1'b0, 1'b0, {6'h00, 6'd12, 2'h3}, 32'h0);
    check("channel enable", 32'h0, {31'h0, hrdata[31]});
    for (int s = 0; s < 8; s++)
    begin
      set_link(1'b1, 1'b0, 1'b0, s[2:0]);
      check("clock ratio", {19'h0, ratio[s]}, {19'h0, clk_ratio});
    end
    set_link(1'b1, 1'b0, 1'b1, 3'h2);
    check("clock ratio pin mode", 32'h0, {19'h0, clk_ratio});
    for (int r = 0; r < 2; r++)
    begin
      set_link(1'b1, r[0], 1'b0, 3'h0);
      @(posedge clk);
      rx_err <= 1'b1;
      tx_en <= 1'b1;
      tx_bit <= r[0];
      @(posedge clk);
      rx_err <= 1'b0;
      @(negedge clk);
      check("retransmit", {31'h0, r[0]}, {31'h0, retx_req});
      check("skip", {31'h0, ~r[0]}, {31'h0, skip_req});
      check("tx data", {30'h0, r[0], 1'b0}, {30'h0, data_o, oe_b});
    end
    set_link(1'b0, 1'b0, 1'b0, 3'h0);
    check("oe_b off", 32'h1, {31'h0, oe_b});
    send_frame({8'hA5, 8'h00});
    check("edges off", 32'h0, edge_cnt);
    set_link(1'b1, 1'b0, 1'b0, 3'h0);
    send_frame({8'hA5, 8'h00});
    send_frame({8'hA5, 8'h00});
    check("lock two frames", 32'h0, {31'h0, lock});
    check("edges on", FB * 2, edge_cnt);
    check("rx data low", 32'h0, {31'h0, rx_bit});
    send_frame({8'hA5, 8'h00});
    check("lock three frames", 32'h1, {31'h0, lock});
    send_frame({8'hA5, 8'hA5});
    check("rx data high", 32'h1, {31'h0, rx_bit});
    send_frame(16'h0000);
    check("lock one miss", 32'h1, {31'h0, lock});
    send_frame(16'h0000);
    check("lock two misses", 32'h0, {31'h0, lock});
    print_verdict();
  end
endmodule
`default_nettype wire
